// ===== verilog/windowed_watchdog.sv
// Windowed watchdog timer with a classic Wishbone register slave.
// Summary of operation
// [R1] Time-out without valid reload resets the chip; with reset mode off it raises the interrupt instead.
// [R2] Software must feed inside the window.
// [R3] Feed outside min/max window is a fault.
// [R4] Warning interrupt at programmable counter value.
// [R5] Enable is set-only until watchdog event.
// [R6] Bad feed gives reset, or interrupt.
// [R7] Flag records a watchdog-caused reset.
// [R8] 24-bit counter behind internal prescaler.
// [R9] Time-out 256x4 to 2^24x4 tick periods.
// [R10] Counter ticks from the watchdog oscillator.
// [R11] Good feed reloads counter from time-out.
`timescale 1ns/1ps

module windowed_watchdog
    import wdt_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic watchdog_tick_clock,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic chip_reset_out,
    output logic wdt_irq
);

    // =========================================================
    // Reset release
    // =========================================================
    logic rst_meta_reg;
    logic rst_sync_reg;
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    wire logic rst_n = rst_sync_reg;

    // =========================================================
    // Wishbone slave: ack one cycle after the request, writes at ack
    // =========================================================
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    wire logic req = wb_cyc_i && wb_stb_i;
    wire logic wr = req && wb_we_i && ack_reg && (wb_sel_i == 4'hF);
    wire logic wr_mode = wr && (wb_adr_i == MODE_OFS);
    wire logic wr_tc = wr && (wb_adr_i == TC_OFS);
    wire logic wr_feed = wr && (wb_adr_i == FEED_OFS);
    wire logic wr_warn = wr && (wb_adr_i == WARN_OFS);
    wire logic wr_window = wr && (wb_adr_i == WINDOW_OFS);

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            ack_reg <= req && !ack_reg;
            rdata_reg <= rdata_next;
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    // =========================================================
    // Configuration registers
    // =========================================================
    logic en_reg;
    logic reset_mode_reg;
    logic [23:0] tc_reg;
    logic [23:0] warn_reg;
    logic [23:0] window_reg;
    logic [23:0] cnt_reg;
    logic event_fire;

    // [R5] Set-only enable
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            en_reg <= 1'b0;
            reset_mode_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (event_fire)
                en_reg <= 1'b0;
            else if (wr_mode && wb_dat_i[MODE_EN_BIT])
                en_reg <= 1'b1;
            if (wr_mode && wb_dat_i[MODE_RESET_BIT])
                reset_mode_reg <= 1'b1;
        end
    end

    // [R9] Time-out clamped at minimum
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tc_reg <= TC_RESET;
            warn_reg <= WARN_RESET;
            window_reg <= WINDOW_RESET;
        end
        else if (clk_en)
        begin
            if (wr_tc)
                tc_reg <= (wb_dat_i[23:0] < TC_MIN) ? TC_MIN : wb_dat_i[23:0];
            if (wr_warn)
                warn_reg <= wb_dat_i[23:0];
            if (wr_window)
                window_reg <= wb_dat_i[23:0];
        end
    end

    // =========================================================
    // Feed sequence checker
    // =========================================================
    feed_state_t feed_reg;
    logic feed_ok;
    logic feed_fault;
    wire logic [7:0] feed_byte = wb_dat_i[7:0];

    always_comb
    begin
        feed_ok = 1'b0;
        feed_fault = 1'b0;
        case (feed_reg)
            FEED_IDLE:
            begin
                feed_fault = wr_feed && en_reg && (feed_byte != FEED_FIRST);
            end
            FEED_ARMED:
            begin
                if (wr_feed && feed_byte == FEED_SECOND)
                begin
                    // [R3] Window check on feed
                    if (en_reg && cnt_reg > window_reg)
                    begin
                        feed_fault = 1'b1;
                    end
                    else
                    begin
                        feed_ok = 1'b1;
                    end
                end
                else if (wr_feed || (wr && !wr_feed))
                begin
                    feed_fault = en_reg;
                end
            end
            default:
            begin
                feed_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            feed_reg <= FEED_IDLE;
        else if (clk_en)
        begin
            if (wr_feed && feed_reg == FEED_IDLE && feed_byte == FEED_FIRST)
                feed_reg <= FEED_ARMED;
            else if (wr)
                feed_reg <= FEED_IDLE;
        end
    end

    // =========================================================
    // Tick prescaler and counter
    // =========================================================
    logic tick_prev_reg;
    logic [1:0] presc_reg;
    // [R10] Count only oscillator edges
    wire logic tick_rise = watchdog_tick_clock && !tick_prev_reg;
    wire logic presc_done = tick_rise && (presc_reg == 2'(PRESCALE_TICKS - 1));
    wire logic timeout = en_reg && presc_done && (cnt_reg == 24'h00_0000);

    // [R8] Divide ticks by four
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_prev_reg <= 1'b0;
            presc_reg <= 2'b00;
        end
        else if (clk_en)
        begin
            tick_prev_reg <= watchdog_tick_clock;
            if (!en_reg || feed_ok)
                presc_reg <= 2'b00;
            else if (tick_rise)
                presc_reg <= presc_reg + 2'b01;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_reg <= TC_RESET;
        else if (clk_en)
        begin
            // [R11] Reload on good feed
            if (feed_ok || !en_reg)
                cnt_reg <= tc_reg;
            else if (presc_done && cnt_reg != 24'h00_0000)
                cnt_reg <= cnt_reg - 24'h00_0001;
        end
    end

    // =========================================================
    // Events, flags and outputs
    // =========================================================
    // [R6] Fault or time-out fires
    assign event_fire = timeout || (feed_fault && en_reg);

    logic tof_reg;
    logic warnf_reg;
    logic rstf_reg;
    logic rst_out_reg;
    logic irq_reg;
    logic [7:0] pulse_cnt_reg;
    wire logic warn_hit = en_reg && presc_done && (cnt_reg == warn_reg);
    wire logic clr_tof = wr_mode && wb_dat_i[MODE_TOF_BIT];
    wire logic clr_warn = wr_mode && wb_dat_i[MODE_WARNF_BIT];
    wire logic clr_rstf = wr_mode && wb_dat_i[MODE_RSTF_BIT];

    // Flags: a setting event wins over a clear in the same cycle.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tof_reg <= 1'b0;
            warnf_reg <= 1'b0;
            rstf_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (event_fire && !reset_mode_reg)
                tof_reg <= 1'b1;
            else if (clr_tof)
                tof_reg <= 1'b0;
            // [R4] Warning flag
            if (warn_hit)
                warnf_reg <= 1'b1;
            else if (clr_warn)
                warnf_reg <= 1'b0;
            // [R7] Watchdog reset flag
            if (event_fire && reset_mode_reg)
                rstf_reg <= 1'b1;
            else if (clr_rstf)
                rstf_reg <= 1'b0;
        end
    end

    // [R1] Chip reset pulse
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pulse_cnt_reg <= 8'h00;
            rst_out_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (event_fire && reset_mode_reg)
            begin
                pulse_cnt_reg <= 8'(RESET_PULSE_CYC);
                rst_out_reg <= 1'b1;
            end
            else if (pulse_cnt_reg > 8'h01)
            begin
                pulse_cnt_reg <= pulse_cnt_reg - 8'h01;
            end
            else
            begin
                pulse_cnt_reg <= 8'h00;
                rst_out_reg <= 1'b0;
            end
            irq_reg <= tof_reg || warnf_reg;
        end
    end
    assign chip_reset_out = rst_out_reg;
    assign wdt_irq = irq_reg;

    // =========================================================
    // Read mux
    // =========================================================
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        if (req && !wb_we_i && !ack_reg)
        begin
            case (wb_adr_i)
                MODE_OFS:
                begin
                    rdata_next[MODE_EN_BIT] = en_reg;
                    rdata_next[MODE_RESET_BIT] = reset_mode_reg;
                    rdata_next[MODE_TOF_BIT] = tof_reg;
                    rdata_next[MODE_WARNF_BIT] = warnf_reg;
                    rdata_next[MODE_RSTF_BIT] = rstf_reg;
                end
                TC_OFS: rdata_next[23:0] = tc_reg;
                TV_OFS: rdata_next[23:0] = cnt_reg;
                WARN_OFS: rdata_next[23:0] = warn_reg;
                WINDOW_OFS: rdata_next[23:0] = window_reg;
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

endmodule

// ===== verilog/wdt_pkg.sv
// Constants shared by the windowed watchdog: register map, reset values and timing.
package wdt_pkg;

    // =========================================================
    // Register offsets (byte addresses, one word each)
    // =========================================================
    localparam logic [7:0] MODE_OFS = 8'h00;
    localparam logic [7:0] TC_OFS = 8'h04;
    localparam logic [7:0] FEED_OFS = 8'h08;
    localparam logic [7:0] TV_OFS = 8'h0C;
    localparam logic [7:0] WARN_OFS = 8'h10;
    localparam logic [7:0] WINDOW_OFS = 8'h14;

    // =========================================================
    // Mode register fields
    // =========================================================
    localparam int MODE_EN_BIT = 0;
    localparam int MODE_RESET_BIT = 1;
    localparam int MODE_TOF_BIT = 2;
    localparam int MODE_WARNF_BIT = 3;
    localparam int MODE_RSTF_BIT = 4;

    // =========================================================
    // Widths, reset values and feed codes
    // =========================================================
    localparam int CNT_W = 24;
    localparam logic [23:0] TC_RESET = 24'hFF_FFFF;
    localparam logic [23:0] TC_MIN = 24'h00_00FF;
    localparam logic [23:0] WARN_RESET = 24'h00_0000;
    localparam logic [23:0] WINDOW_RESET = 24'hFF_FFFF;
    localparam logic [7:0] FEED_FIRST = 8'hAA;
    localparam logic [7:0] FEED_SECOND = 8'h55;

    // =========================================================
    // Timing
    // =========================================================
    localparam int PRESCALE_TICKS = 4;
    localparam int CLK_HZ = 25000000;
    localparam int RESET_PULSE_NS = 200;
    localparam int RESET_PULSE_CYC = (RESET_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;

    typedef enum logic [1:0] {FEED_IDLE, FEED_ARMED} feed_state_t;

endpackage

// ===== bench/windowed_watchdog_asserts.sv
// Concurrent checks on the ports of the windowed watchdog.
`timescale 1ns/1ps

module wdt_checker
    import wdt_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic watchdog_tick_clock,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic chip_reset_out,
    input wire logic wdt_irq
);
    // ==========================================================
    // Bus and output checks
    // ==========================================================
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    // Reset has been seen at an earlier edge, so the outputs have settled.
    logic rst_held = 1'b0;
    always @(posedge ref_clk)
        rst_held <= !resetn;

    // The reset pulse stands exactly five cycles, then drops.
    sequence pulse_s;
        chip_reset_out [*5] ##1 !chip_reset_out;
    endsequence

    a_ack_follows_req: assert property ($rose(wb_cyc_i && wb_stb_i) && clk_en |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_has_cause: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i && $past(wb_stb_i))
        else $error("ack without request");
    a_data_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside ack");
    a_unmapped_reads_zero: assert property (wb_ack_o && !wb_we_i
        && (wb_adr_i > WINDOW_OFS || wb_adr_i[1:0] != 2'b00) |-> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_count_width: assert property (wb_ack_o && !wb_we_i && wb_adr_i == TV_OFS |->
        wb_dat_o[31:24] == 8'h00)
        else $error("counter wider than 24 bits");
    a_reset_pulse_len: assert property ($rose(chip_reset_out) |-> pulse_s)
        else $error("reset pulse length wrong");
    a_reset_quiet: assert property (disable iff (1'b0)
        !resetn && rst_held |-> !chip_reset_out && !wdt_irq && !wb_ack_o)
        else $error("output active in reset");
endmodule

bind windowed_watchdog wdt_checker chk_u (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en),
    .watchdog_tick_clock(watchdog_tick_clock), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .chip_reset_out(chip_reset_out),
    .wdt_irq(wdt_irq));

// ===== bench/windowed_watchdog_timer_bench.sv
// Self-checking bench for the windowed watchdog.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end

module windowed_watchdog_timer_bench
    import wdt_pkg::*;
;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic tick = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic got;
    logic [1:0] tdiv = 2'b00;
    logic [3:0] sel = 4'h0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0000_0000;
    logic [31:0] rd;
    logic [31:0] tv1;
    logic [3:0] bsel = 4'hF;
    logic ce = 1'b1;
    logic [31:0] dat_o;
    logic ack;
    logic rst_o;
    logic irq;
    int miscompares = 0;
    int n_compared = 0;
    int ticks = 0;
    int t0;
    int n;

    always #20 ref_clk = ~ref_clk;

    // A tick rises every fourth clock, well below half the clock rate.
    always @(posedge ref_clk)
    begin
        tdiv <= tdiv + 2'b01;
        tick <= tdiv[1];
        ticks <= ticks + ((tdiv[1] && !tick) ? 1 : 0);
    end

    windowed_watchdog dut_u (.ref_clk(ref_clk), .resetn(resetn), .clk_en(ce),
        .watchdog_tick_clock(tick), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .chip_reset_out(rst_o), .wdt_irq(irq));

    // ==========================================================
    // Bus tasks
    // ==========================================================
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        n = 0;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        sel <= bsel;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        `CHK("ack", 1'b1, ack)
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
        xfer(1'b0, a, 32'h0000_0000);
        `CHK(nm, e, rd)
    endtask

    task automatic feed(input logic [7:0] b2);
        wr(FEED_OFS, {24'h00_0000, FEED_FIRST});
        wr(FEED_OFS, {24'h00_0000, b2});
    endtask

    task automatic wait_hi(input logic on_rst, input int lim);
        n = 0;
        got = 1'b0;
        while (n < lim && !got)
        begin
            @(posedge ref_clk);
            got = ((on_rst ? rst_o : irq) === 1'b1);
            n++;
        end
    endtask

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (40000) @(posedge ref_clk);
        miscompares++;
        stop_test();
    end

    // ==========================================================
    // Test sequence
    // ==========================================================
    initial
    begin
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd_chk(MODE_OFS, 32'h0000_0000, "mode");
        rd_chk(TC_OFS, {8'h00, TC_RESET}, "timeout");
        rd_chk(WARN_OFS, 32'h0000_0000, "warning");
        rd_chk(WINDOW_OFS, {8'h00, WINDOW_RESET}, "window");
        rd_chk(TV_OFS, {8'h00, TC_RESET}, "count");
        rd_chk(8'h20, 32'h0000_0000, "unmapped");
        wr(TC_OFS, 32'h0000_0010);
        rd_chk(TC_OFS, {8'h00, TC_MIN}, "timeout floor");
        // A write without all byte lanes is acknowledged but ignored.
        bsel = 4'h1;
        wr(TC_OFS, 32'h0000_1234);
        bsel = 4'hF;
        rd_chk(TC_OFS, {8'h00, TC_MIN}, "partial write");
        wr(WARN_OFS, 32'h0000_0080);
        wr(MODE_OFS, 32'h0000_0001);
        t0 = ticks;
        wr(MODE_OFS, 32'h0000_0000);
        rd_chk(MODE_OFS, 32'h0000_0001, "enable held");
        wait_hi(1'b0, 6000);
        `CHK("warning irq", 1'b1, got)
        rd_chk(MODE_OFS, 32'h0000_0009, "warning flag");
        wr(MODE_OFS, 32'h0000_0008);
        repeat (3) @(posedge ref_clk);
        `CHK("irq cleared", 1'b0, irq)
        wait_hi(1'b0, 6000);
        `CHK("timeout ticks", 1'b1, (ticks - t0 >= 1020 && ticks - t0 <= 1030))
        rd_chk(MODE_OFS, 32'h0000_0004, "timeout flag");
        wr(MODE_OFS, 32'h0000_0007);
        // Stay above the warning position so that the interrupt stays idle.
        repeat (1600) @(posedge ref_clk);
        feed(FEED_SECOND);
        xfer(1'b0, TV_OFS, 32'h0000_0000);
        `CHK("reload", 1'b1, (rd[23:0] >= 24'h00_00FE))
        `CHK("irq idle", 1'b0, irq)
        feed(8'h12);
        wait_hi(1'b1, 20);
        `CHK("bad feed reset", 1'b1, got)
        rd_chk(MODE_OFS, 32'h0000_0012, "reset flag");
        wr(WINDOW_OFS, 32'h0000_0040);
        wr(MODE_OFS, 32'h0000_0011);
        feed(FEED_SECOND);
        wait_hi(1'b1, 20);
        `CHK("early feed reset", 1'b1, got)
        wr(MODE_OFS, 32'h0000_0011);
        do xfer(1'b0, TV_OFS, 32'h0000_0000); while (rd[23:0] > 24'h00_003F);
        feed(FEED_SECOND);
        wait_hi(1'b1, 20);
        `CHK("window feed", 1'b0, got)
        // With the clock enable low the counter must hold its value.
        xfer(1'b0, TV_OFS, 32'h0000_0000);
        tv1 = rd;
        ce <= 1'b0;
        repeat (400) @(posedge ref_clk);
        ce <= 1'b1;
        xfer(1'b0, TV_OFS, 32'h0000_0000);
        `CHK("frozen count", 1'b1, (tv1[23:0] - rd[23:0] <= 24'h00_0001))
        wait_hi(1'b1, 6000);
        `CHK("timeout reset", 1'b1, got)
        rd_chk(MODE_OFS, 32'h0000_001A, "reset cause");
        stop_test();
    end
endmodule
